// ===== core/svd_pkg.sv
package svd_pkg;
    // register indexes; byte address is four times the index
    localparam logic [11:0] CTRL_IDX = 12'hf85;
    localparam logic [11:0] STAT_IDX = 12'hf86;
    localparam logic [11:0] MASK_IDX = 12'hf87;
    localparam logic [15:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
    localparam logic [15:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};
    localparam logic [15:0] MASK_ADDR = {2'h0, MASK_IDX, 2'h0};

    // control register fields
    localparam int DIR_BIT = 7;
    localparam int BG_BIT = 6;
    localparam int REF_BIT = 5;
    localparam int EN_BIT = 4;
    localparam int LEVEL_LSB = 0;
    localparam int LEVEL_W = 4;
    localparam logic [3:0] LEVEL_EXT = 4'hf;
    localparam logic [3:0] LEVEL_RESET = 4'h0;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // status and mask share one layout
    localparam int FLAG_BIT = 0;
    localparam logic MASK_RESET = 1'h0;

    // synchroniser lanes
    localparam int SYNC_W = 4;
    localparam int SY_GE = 0;
    localparam int SY_LE = 1;
    localparam int SY_REF = 2;
    localparam int SY_BG = 3;
    localparam int SYNC_STAGES = 2;
endpackage : svd_pkg

// ===== core/svd_trip_detector.sv
// Design decision made here: the APB slave port.
module svd_trip_detector (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmp_ge,
    input wire logic cmp_le,
    input wire logic ref_settled,
    input wire logic bandgap_ok,
    output logic detector_power,
    output logic [3:0] trip_level,
    output logic external_sense_sel,
    output logic trip_direction,
    output logic irq,
    output logic wake_req
);

    // whole state of the block in one record
    typedef struct packed {
        logic ctrl_dir;
        logic ctrl_en;
        logic [3:0] ctrl_level;
        logic en_q;
        logic ref_stable;
        logic bg_stable;
        logic flag;
        logic mask;
        logic [31:0] rdata;
        logic [3:0] sync1;
        logic [3:0] sync2;
    } svd_state_s;

    svd_state_s s;
    svd_state_s next_s;

    logic setup_ph;
    logic access_ph;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_mask;
    logic mapped;
    logic trip_hit;
    logic set_flag;
    logic [7:0] ctrl_view;
    logic [3:0] raw_in;

    // apb phase and address decode
    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;
    assign hit_ctrl = (paddr == svd_pkg::CTRL_ADDR);
    assign hit_stat = (paddr == svd_pkg::STAT_ADDR);
    assign hit_mask = (paddr == svd_pkg::MASK_ADDR);
    assign mapped = hit_ctrl | hit_stat | hit_mask;

    // analog indications gathered into lanes, one per synchroniser bit
    genvar gi;
    generate
        for (gi = 0; gi < svd_pkg::SYNC_W; gi++)
        begin : g_lane
            if (gi == svd_pkg::SY_GE)
            begin : g_ge
                assign raw_in[gi] = cmp_ge;
            end
            else if (gi == svd_pkg::SY_LE)
            begin : g_le
                assign raw_in[gi] = cmp_le;
            end
            else if (gi == svd_pkg::SY_REF)
            begin : g_ref
                assign raw_in[gi] = ref_settled;
            end
            else
            begin : g_bg
                assign raw_in[gi] = bandgap_ok;
            end
        end
    endgenerate

    // comparator result for the chosen direction, taken only after two stages
    assign trip_hit = s.ctrl_dir ? s.sync2[svd_pkg::SY_GE]
                                 : s.sync2[svd_pkg::SY_LE];
    // the flag may only set while enabled and the reference is settled
    assign set_flag = s.ctrl_en & s.ref_stable & trip_hit;

    // readable control view; status bits come from the block, not software
    always_comb
    begin
        ctrl_view = svd_pkg::CTRL_RESET;
        ctrl_view[svd_pkg::DIR_BIT] = s.ctrl_dir;
        ctrl_view[svd_pkg::BG_BIT] = s.bg_stable;
        ctrl_view[svd_pkg::REF_BIT] = s.ref_stable;
        ctrl_view[svd_pkg::EN_BIT] = s.ctrl_en;
        ctrl_view[svd_pkg::LEVEL_LSB +: svd_pkg::LEVEL_W] = s.ctrl_level;
    end

    // next state; nothing moves while the clock enable is low
    always_comb
    begin
        next_s = s;
        if (pce)
        begin
            // first stage feeds only the second
            next_s.sync1 = raw_in;
            next_s.sync2 = s.sync1;
            next_s.en_q = s.ctrl_en;

            // software writes land at the end of the access phase
            if (access_ph && pwrite && hit_ctrl)
            begin
                // status bits 6 and 5 are not writable
                next_s.ctrl_dir = pwdata[svd_pkg::DIR_BIT];
                next_s.ctrl_en = pwdata[svd_pkg::EN_BIT];
                next_s.ctrl_level = pwdata[svd_pkg::LEVEL_LSB +: svd_pkg::LEVEL_W];
            end
            if (access_ph && pwrite && hit_mask)
            begin
                next_s.mask = pwdata[svd_pkg::FLAG_BIT];
            end

            // settle time is whatever the analog reference takes; a fresh
            // enable forces at least one cycle of not-stable so a stale
            // settled level from an earlier enable can never leak through
            if (!s.ctrl_en || !s.en_q)
            begin
                next_s.ref_stable = 1'b0;
            end
            else
            begin
                next_s.ref_stable = s.sync2[svd_pkg::SY_REF];
            end
            next_s.bg_stable = s.sync2[svd_pkg::SY_BG];

            // read clears only what the read reported; a new event wins
            if (access_ph && !pwrite && hit_stat && s.rdata[svd_pkg::FLAG_BIT])
            begin
                next_s.flag = 1'b0;
            end
            if (set_flag)
            begin
                next_s.flag = 1'b1;
            end

            // read data is prepared in the setup phase
            if (setup_ph && !pwrite)
            begin
                next_s.rdata = 32'h0000_0000;
                if (hit_ctrl)
                begin
                    next_s.rdata[7:0] = ctrl_view;
                end
                else if (hit_stat)
                begin
                    next_s.rdata[svd_pkg::FLAG_BIT] = s.flag;
                end
                else if (hit_mask)
                begin
                    next_s.rdata[svd_pkg::FLAG_BIT] = s.mask;
                end
            end
        end
    end

    // register the record; reset returns the detector to disabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    // apb answers with no wait states; unmapped addresses get an error
    assign pready = 1'b1;
    assign pslverr = access_ph & ~mapped;
    assign prdata = s.rdata;

    // analog side controls
    assign detector_power = s.ctrl_en;
    assign trip_level = s.ctrl_level;
    assign external_sense_sel = (s.ctrl_level == svd_pkg::LEVEL_EXT);
    assign trip_direction = s.ctrl_dir;
    // the flag is kept even when masked; only the request is gated
    assign irq = s.flag & s.mask;
    // wake does not depend on pclk running beyond the flag capture
    assign wake_req = s.flag;

    // named steps used by the checks below
    sequence seq_ctrl_write;
        pce && psel && penable && pwrite && hit_ctrl;
    endsequence

    sequence seq_stat_read;
        pce && psel && penable && !pwrite && hit_stat;
    endsequence

    sequence seq_enable_rise;
        pce && s.ctrl_en && !s.en_q;
    endsequence

    AST_DIR_GE: assert property (@(posedge pclk) disable iff (!presetn)
        pce && s.ctrl_en && s.ref_stable && s.ctrl_dir && s.sync2[svd_pkg::SY_GE] |=> s.flag)
        else $error("high direction crossing did not set flag");

    AST_DIR_LE: assert property (@(posedge pclk) disable iff (!presetn)
        pce && s.ctrl_en && s.ref_stable && !s.ctrl_dir && s.sync2[svd_pkg::SY_LE] |=> s.flag)
        else $error("low direction crossing did not set flag");

    AST_FLAG_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
        s.flag && !(pce && psel && penable && !pwrite && hit_stat) |=> s.flag)
        else $error("event flag dropped without a status read");

    AST_IRQ_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        (s.flag && !s.mask |-> !irq) and (s.flag && s.mask |-> irq))
        else $error("interrupt output disagrees with flag and mask");

    AST_OFF_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
        pce && !s.ctrl_en && !s.flag |=> !s.flag)
        else $error("disabled detector set the event flag");

    AST_POWER_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        seq_ctrl_write ##0 !pwdata[svd_pkg::EN_BIT] |=> !detector_power)
        else $error("clearing enable left detector powered");

    AST_REF_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        seq_enable_rise |-> !s.ref_stable ##1 (!pce || !s.ref_stable || s.en_q))
        else $error("reference stable shown on enable rise");

    AST_NO_EARLY_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        pce && !s.ref_stable && !s.flag |=> !s.flag)
        else $error("flag set before reference stable");

    AST_EXT_SEL: assert property (@(posedge pclk) disable iff (!presetn)
        seq_ctrl_write ##0 pwdata[svd_pkg::LEVEL_LSB +: svd_pkg::LEVEL_W] == svd_pkg::LEVEL_EXT
        |=> external_sense_sel)
        else $error("level 1111 did not select external pin");

    AST_SYNC_DEPTH: assert property (@(posedge pclk) disable iff (!presetn)
        pce && s.ctrl_en && s.en_q && $past(pce) && $rose(s.ref_stable) |-> $past(s.sync2[svd_pkg::SY_REF]))
        else $error("reference stable rose without synchronised settle");

    // a read clears only a flag it reported, and only when no new event lands
    AST_READ_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        seq_stat_read ##0 (s.rdata[svd_pkg::FLAG_BIT] && !set_flag) |=> !s.flag)
        else $error("status read did not clear reported flag");

    AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
        pce && set_flag |=> s.flag)
        else $error("event lost against a same cycle clear");

    AST_FREEZE: assert property (@(posedge pclk) disable iff (!presetn)
        !pce |=> $stable(s))
        else $error("state moved while clock enable low");

    AST_REF_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        pce && !s.ctrl_en |=> !s.ref_stable)
        else $error("reference stable shown while disabled");

    AST_REF_FOLLOW: assert property (@(posedge pclk) disable iff (!presetn)
        pce && s.ctrl_en && s.en_q |=> s.ref_stable == $past(s.sync2[svd_pkg::SY_REF]))
        else $error("reference stable does not follow settled indication");

    AST_BG_FOLLOW: assert property (@(posedge pclk) disable iff (!presetn)
        pce |=> s.bg_stable == $past(s.sync2[svd_pkg::SY_BG]))
        else $error("bandgap stable does not follow its indication");

    AST_SYNC_CHAIN: assert property (@(posedge pclk) disable iff (!presetn)
        pce |=> s.sync2 == $past(s.sync1))
        else $error("second synchroniser stage skipped the first");

    AST_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
        pce && set_flag |=> wake_req)
        else $error("event did not raise wake request");

    AST_NO_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable |-> pready)
        else $error("access phase was stretched");

    AST_SLVERR: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable |-> pslverr == !mapped)
        else $error("error response disagrees with address map");

    AST_MASK_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        pce && psel && penable && pwrite && hit_mask |=> s.mask == $past(pwdata[svd_pkg::FLAG_BIT]))
        else $error("mask write did not land");

    AST_CTRL_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        seq_ctrl_write |=> detector_power == $past(pwdata[svd_pkg::EN_BIT])
            && trip_direction == $past(pwdata[svd_pkg::DIR_BIT]))
        else $error("control write did not land");

    AST_EXT_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        s.ctrl_level != svd_pkg::LEVEL_EXT |-> !external_sense_sel)
        else $error("external pin selected by an internal level");

    AST_READ_DATA: assert property (@(posedge pclk) disable iff (!presetn)
        pce && setup_ph && !pwrite && hit_ctrl |=> prdata[7:0] == $past(ctrl_view))
        else $error("control read data not loaded in setup phase");

endmodule : svd_trip_detector

// ===== verif/svd_analog_model.sv
module svd_analog_model (
    input wire logic pclk,
    input wire logic power,
    input wire logic ext_sel,
    input wire logic [3:0] level,
    input wire logic [7:0] volts,
    output logic cmp_ge,
    output logic cmp_le,
    output logic ref_settled
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] EXT_TRIP = 8'h40;
    int settle_cnt;
    logic [7:0] trip;
    // the external pin is judged against its own fixed trip point
    assign trip = ext_sel ? EXT_TRIP : {level, 4'h0};
    // a powered-down comparator reports no hit either way
    assign cmp_ge = power && (volts >= trip);
    assign cmp_le = power && (volts <= trip);
    // settling lives in the analog model, so the design cannot lean on a cycle count
    always @(posedge pclk or negedge power)
    begin
        if (!power)
            settle_cnt <= 0;
        else if (settle_cnt < 20)
            settle_cnt <= settle_cnt + 1;
    end
    assign ref_settled = (settle_cnt >= 20);
endmodule : svd_analog_model

// ===== verif/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, pce, psel, penable, pwrite, pready, pslverr, err, bandgap_ok, mask;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic cmp_ge, cmp_le, ref_settled, detector_power, external_sense_sel, trip_direction, irq, wake_req;
    logic [3:0] trip_level;
    logic [7:0] volts;
    int fails, n_checks, cyc;
    logic [7:0] ct [8] = '{8'h98, 8'h98, 8'h18, 8'h18, 8'h88, 8'h9f, 8'h9e, 8'h9f};
    logic [7:0] vh [8] = '{8'h80, 8'h7f, 8'h80, 8'h81, 8'hff, 8'h50, 8'h50, 8'h40};
    logic ex [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

    svd_trip_detector u_svd_trip_detector (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_ge(cmp_ge), .cmp_le(cmp_le), .ref_settled(ref_settled), .bandgap_ok(bandgap_ok),
        .detector_power(detector_power), .trip_level(trip_level), .external_sense_sel(external_sense_sel),
        .trip_direction(trip_direction), .irq(irq), .wake_req(wake_req));
    svd_analog_model u_svd_analog_model (.pclk(pclk), .power(detector_power), .ext_sel(external_sense_sel),
        .level(trip_level), .volts(volts), .cmp_ge(cmp_ge), .cmp_le(cmp_le), .ref_settled(ref_settled));

    // 100 ns period
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    // the whole run needs about 850 cycles
    always @(posedge pclk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            fails = fails + 1;
            tally_and_finish();
        end
    end

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // one apb transfer; read data and error are taken at the edge that sees pready
    task apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // the excursion is removed before the status read, so only a sticky flag survives
    task excursion(input logic [7:0] c, input logic [7:0] v, input logic e);
        logic [7:0] safe;
        safe = c[7] ? 8'h00 : 8'hff;
        volts <= safe;
        apb(1'b1, svd_pkg::CTRL_ADDR, {24'h0, c});
        repeat (26) @(posedge pclk);
        check("trip_direction", {31'h0, c[7]}, {31'h0, trip_direction});
        check("trip_level", {28'h0, c[3:0]}, {28'h0, trip_level});
        apb(1'b0, svd_pkg::STAT_ADDR, 32'h0);
        volts <= v;
        repeat (6) @(posedge pclk);
        check("irq", {31'h0, e & mask}, {31'h0, irq});
        check("wake_req", {31'h0, e}, {31'h0, wake_req});
        volts <= safe;
        repeat (4) @(posedge pclk);
        apb(1'b0, svd_pkg::STAT_ADDR, 32'h0);
        check("flag", {31'h0, e}, rd);
        apb(1'b0, svd_pkg::STAT_ADDR, 32'h0);
        check("flag after read", 32'h0, rd);
    endtask : excursion

    initial
    begin
        presetn = 1'b0;
        pce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        bandgap_ok = 1'b0;
        volts = 8'h00;
        mask = 1'b0;
        fails = 0;
        n_checks = 0;
        cyc = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, svd_pkg::CTRL_ADDR, 32'h0);
        check("ctrl reset", 32'h0, rd);
        bandgap_ok <= 1'b1;
        apb(1'b1, svd_pkg::CTRL_ADDR, 32'hff);
        volts <= 8'hff;
        repeat (3) @(posedge pclk);
        volts <= 8'h00;
        apb(1'b0, svd_pkg::CTRL_ADDR, 32'h0);
        check("ctrl unsettled", 32'hdf, rd);
        check("ext select", 32'h1, {31'h0, external_sense_sel});
        check("power", 32'h1, {31'h0, detector_power});
        repeat (25) @(posedge pclk);
        apb(1'b0, svd_pkg::CTRL_ADDR, 32'h0);
        check("ctrl settled", 32'hff, rd);
        apb(1'b0, svd_pkg::STAT_ADDR, 32'h0);
        check("early flag", 32'h0, rd);
        $display("register and settle test done");
        for (int m = 0; m < 2; m++)
        begin
            mask = m[0];
            apb(1'b1, svd_pkg::MASK_ADDR, {31'h0, mask});
            apb(1'b0, svd_pkg::MASK_ADDR, 32'h0);
            check("mask", {31'h0, mask}, rd);
            for (int i = 0; i < 8; i++)
                excursion(ct[i], vh[i], ex[i]);
        end
        $display("excursion test done");
        // a write while the clock enable is low must not land
        pce <= 1'b0;
        apb(1'b1, svd_pkg::MASK_ADDR, 32'h0);
        pce <= 1'b1;
        apb(1'b0, svd_pkg::MASK_ADDR, 32'h0);
        check("mask frozen", {31'h0, mask}, rd);
        // reset in mid-run turns the detector off again
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check("power in reset", 32'h0, {31'h0, detector_power});
        presetn <= 1'b1;
        apb(1'b0, svd_pkg::CTRL_ADDR, 32'h0);
        check("ctrl after reset", 32'h0, rd);
        apb(1'b0, svd_pkg::MASK_ADDR, 32'h0);
        check("mask after reset", 32'h0, rd);
        $display("freeze and reset test done");
        apb(1'b0, 16'h0010, 32'h0);
        check("unmapped data", 32'h0, rd);
        check("unmapped error", 32'h1, {31'h0, err});
        $display("unmapped test done");
        tally_and_finish();
    end
endmodule : tb
